// ### logic/ell_pkg.sv
package ell_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_LATCH   = 4'h4;
    localparam logic [3:0] OFS_STATUS  = 4'h8;
    localparam logic [3:0] OFS_IRQCLR  = 4'hC;

    localparam logic [3:0] OFS_IRQEN   = 4'h0;
    localparam logic [3:0] OFS_FSM     = 4'h4;
    localparam logic [3:0] OFS_DOUT    = 4'h8;
    localparam logic [3:0] OFS_ENCRDY  = 4'hC;
    localparam logic       PAGE_LO     = 1'b0;
    localparam logic       PAGE_HI     = 1'b1;

    // Control register field positions
    localparam int CTRL_ZERO_BIT  = 0;
    localparam int CTRL_RISE_BIT  = 1;
    localparam int CTRL_FALL_BIT  = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status / interrupt event positions
    localparam int EV_ZERO_BIT  = 0;
    localparam int EV_RISE_BIT  = 1;
    localparam int EV_FALL_BIT  = 2;
    localparam int EV_WIDTH     = 3;

    localparam int CNT_WIDTH = 32;

    // Lamp timing, in milliseconds and in clock cycles
    localparam longint CLK_HZ        = 25000000;
    localparam longint BLINK_MS      = 200;
    localparam longint FLICKER_MS    = 50;
    localparam longint SINGLE_OFF_MS = 1000;
    localparam longint BLINK_CYC     = CLK_HZ * BLINK_MS / 1000;
    localparam longint FLICKER_CYC   = CLK_HZ * FLICKER_MS / 1000;
    localparam longint SINGLE_OFF_CYC = CLK_HZ * SINGLE_OFF_MS / 1000;

    // Fieldbus states, Gray coded along the start-up path
    typedef enum logic [2:0] {
        ST_STARTUP   = 3'b000,
        ST_PREP      = 3'b001,
        ST_GUARDED   = 3'b011,
        ST_RUNNING   = 3'b010,
        ST_FWLOAD    = 3'b110
    } ell_state_t;

endpackage

// ### logic/ell_edge_det.sv
`timescale 1ns/10ps
// Two-stage synchroniser followed by an edge detector
module ell_edge_det (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per sampled transition
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;  // see R10
    assign fall  = ~sync_reg & last_reg;  // see R10
endmodule

// ### logic/ell_latch_leds.sv
`timescale 1ns/10ps
// What this block does
// R01: Zero-track rising edge copies counter to latch when its enable set.
// R02: Latch pin rising edge copies counter to latch when enabled.
// R03: Latch pin falling edge copies counter to latch when enabled.
// R04: State lamp: off, blink, single flash, steady, flicker per state.
// R05: Encoder lamp lit only while encoder interface is ready.
// R06: Each track lamp lit while its encoder input carries a signal.
// R07: Input lamp lit while the digital input is asserted.
// R08: Output lamp lit while the digital output is driven active.
// R09: Outputs held safe outside running state; process data only there.
// R10: Inputs synchronised; edges found by comparing samples, one capture.
module ell_latch_leds
#(
    parameter longint BLINK_CYCLES      = ell_pkg::BLINK_CYC,
    parameter longint FLICKER_CYCLES    = ell_pkg::FLICKER_CYC,
    parameter longint SINGLE_OFF_CYCLES = ell_pkg::SINGLE_OFF_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic [3:0]                  avsAddress,
    input  wire logic                        avsRead,
    input  wire logic                        avsWrite,
    input  wire logic [31:0]                 avsWriteData,
    input  wire logic [3:0]                  avsByteEnable,
    input  wire logic                        avsPage,
    output logic [31:0]                      avsReadData,
    output logic                             avsWaitRequest,
    input  wire logic [ell_pkg::CNT_WIDTH-1:0] counterValue,
    input  wire logic                        trackA,
    input  wire logic                        trackB,
    input  wire logic                        trackZero,
    input  wire logic                        latchPin,
    input  wire logic                        digitalIn,
    output logic                             digitalOut,
    output logic                             lampState,
    output logic                             lampEncoder,
    output logic                             lampTrackA,
    output logic                             lampTrackB,
    output logic                             lampTrackZero,
    output logic                             lampInput,
    output logic                             lampOutput,
    output logic                             irq
);
    import ell_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic zeroLvl;
    logic zeroRise;
    logic latchRise;
    logic latchFall;
    logic trackALvl;
    logic trackBLvl;
    logic inLvl;

    ell_edge_det uZero (
        .clk   (clk),
        .rstn  (rstn),
        .pinIn (trackZero),
        .level (zeroLvl),
        .rise  (zeroRise),
        .fall  ()
    );

    ell_edge_det uLatch (
        .clk   (clk),
        .rstn  (rstn),
        .pinIn (latchPin),
        .level (),
        .rise  (latchRise),
        .fall  (latchFall)
    );

    // Lamp-only inputs still pass two flops to keep them metastability-free
    logic [2:0] lampMeta_reg;
    logic [2:0] lampSync_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lampMeta_reg <= 3'h0;
            lampSync_reg <= 3'h0;
        end else begin
            lampMeta_reg <= {digitalIn, trackB, trackA};
            lampSync_reg <= lampMeta_reg;
        end
    end
    assign trackALvl = lampSync_reg[0];
    assign trackBLvl = lampSync_reg[1];
    assign inLvl     = lampSync_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // Software state

    logic [2:0]           ctrl_reg;
    logic [EV_WIDTH-1:0]  irqEn_reg;
    logic [EV_WIDTH-1:0]  status_reg;
    ell_state_t           fsm_reg;
    logic                 doutReq_reg;
    logic                 encRdy_reg;
    logic [CNT_WIDTH-1:0] latch_reg;
    logic                 rdDone_reg;

    function automatic logic hit(input logic [3:0] ofs, input logic pg);
        hit = (avsAddress == ofs) && (avsPage == pg) && avsByteEnable[0];
    endfunction

    // Writes finish at once; a read waits one cycle so its data is registered
    assign avsWaitRequest = avsRead && !rdDone_reg;

    // Control and configuration writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= CTRL_RESET;
            irqEn_reg   <= '0;
            fsm_reg     <= ST_STARTUP;
            doutReq_reg <= 1'b0;
            encRdy_reg  <= 1'b0;
        end else if (avsWrite) begin
            if (hit(OFS_CTRL, PAGE_LO)) begin
                ctrl_reg <= avsWriteData[2:0];
            end
            if (hit(OFS_IRQEN, PAGE_HI)) begin
                irqEn_reg <= avsWriteData[EV_WIDTH-1:0];
            end
            if (hit(OFS_FSM, PAGE_HI)) begin
                case (avsWriteData[2:0])
                    ST_PREP:    fsm_reg <= ST_PREP;
                    ST_GUARDED: fsm_reg <= ST_GUARDED;
                    ST_RUNNING: fsm_reg <= ST_RUNNING;
                    ST_FWLOAD:  fsm_reg <= ST_FWLOAD;
                    default:    fsm_reg <= ST_STARTUP;
                endcase
            end
            if (hit(OFS_DOUT, PAGE_HI)) begin
                doutReq_reg <= avsWriteData[0];
            end
            if (hit(OFS_ENCRDY, PAGE_HI)) begin
                encRdy_reg <= avsWriteData[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture of the counter

    logic [EV_WIDTH-1:0] evt;
    assign evt[EV_ZERO_BIT] = zeroRise  & ctrl_reg[CTRL_ZERO_BIT]; // see R01
    assign evt[EV_RISE_BIT] = latchRise & ctrl_reg[CTRL_RISE_BIT]; // see R02
    assign evt[EV_FALL_BIT] = latchFall & ctrl_reg[CTRL_FALL_BIT]; // see R03

    // Latch register takes the counter on any enabled edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_reg <= '0;
        end else if (|evt) begin
            latch_reg <= counterValue;  // see R01 see R02 see R03
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a clear in the same cycle

    logic [EV_WIDTH-1:0] clrMask;
    assign clrMask = (avsWrite && hit(OFS_IRQCLR, PAGE_LO)) ?
                     avsWriteData[EV_WIDTH-1:0] : '0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clrMask) | evt;
        end
    end

    assign irq = |(status_reg & irqEn_reg);

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered data

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avsReadData <= 32'h0000_0000;
            rdDone_reg  <= 1'b0;
        end else if (avsRead && !rdDone_reg) begin
            rdDone_reg  <= 1'b1;
            avsReadData <= 32'h0000_0000;
            if (hit(OFS_CTRL, PAGE_LO)) begin
                avsReadData[2:0] <= ctrl_reg;
            end
            if (hit(OFS_LATCH, PAGE_LO)) begin
                avsReadData <= latch_reg;
            end
            if (hit(OFS_STATUS, PAGE_LO)) begin
                avsReadData[EV_WIDTH-1:0] <= status_reg;
            end
            if (hit(OFS_IRQEN, PAGE_HI)) begin
                avsReadData[EV_WIDTH-1:0] <= irqEn_reg;
            end
            if (hit(OFS_FSM, PAGE_HI)) begin
                avsReadData[2:0] <= fsm_reg;
            end
            if (hit(OFS_DOUT, PAGE_HI)) begin
                avsReadData[0] <= doutReq_reg;
            end
            if (hit(OFS_ENCRDY, PAGE_HI)) begin
                avsReadData[0] <= encRdy_reg;
            end
        end else begin
            rdDone_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink timing: a cycle counter and a phase counter

    logic [31:0] tick_reg;
    logic [3:0]  phase_reg;
    logic        blinkTick;
    logic        flickTick;
    logic [31:0] flickCnt_reg;
    logic        flick_reg;

    assign blinkTick = (tick_reg == 32'(BLINK_CYCLES - 1));
    assign flickTick = (flickCnt_reg == 32'(FLICKER_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_reg  <= '0;
            phase_reg <= '0;
        end else if (blinkTick) begin
            tick_reg  <= '0;
            phase_reg <= phase_reg + 4'h1;
        end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flickCnt_reg <= '0;
            flick_reg    <= 1'b0;
        end else if (flickTick) begin
            flickCnt_reg <= '0;
            flick_reg    <= ~flick_reg;
        end else begin
            flickCnt_reg <= flickCnt_reg + 32'h0000_0001;
        end
    end

    // Single flash: lit in one blink slot out of a long period
    localparam logic [3:0] SINGLE_SLOTS =
        4'((SINGLE_OFF_CYCLES + BLINK_CYCLES) / BLINK_CYCLES);
    logic singleOn;
    assign singleOn = (phase_reg % SINGLE_SLOTS) == 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Lamps and process output, all from flops

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lampState <= 1'b0;
        end else begin
            case (fsm_reg)
                ST_STARTUP: lampState <= 1'b0;           // see R04
                ST_PREP:    lampState <= phase_reg[0];   // see R04
                ST_GUARDED: lampState <= singleOn;       // see R04
                ST_RUNNING: lampState <= 1'b1;           // see R04
                ST_FWLOAD:  lampState <= flick_reg;      // see R04
                default:    lampState <= 1'b0;
            endcase
        end
    end

    // Output held safe (off) unless running; lamps mirror the pins, the encoder lamp mirrors encRdy_reg
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            digitalOut    <= 1'b0;
            lampOutput    <= 1'b0;
            lampEncoder   <= 1'b0;
            lampTrackA    <= 1'b0;
            lampTrackB    <= 1'b0;
            lampTrackZero <= 1'b0;
            lampInput     <= 1'b0;
        end else begin
            digitalOut    <= doutReq_reg && (fsm_reg == ST_RUNNING); // see R09
            lampOutput    <= doutReq_reg && (fsm_reg == ST_RUNNING); // see R08
            lampEncoder   <= encRdy_reg;  // see R05
            lampTrackA    <= trackALvl;   // see R06
            lampTrackB    <= trackBLvl;   // see R06
            lampTrackZero <= zeroLvl;     // see R06
            lampInput     <= inLvl;       // see R07
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    zero_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        evt[EV_ZERO_BIT] |=> latch_reg == $past(counterValue)) // see R01
        else $error("zero-track capture missed");
    rise_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        evt[EV_RISE_BIT] |=> latch_reg == $past(counterValue)) // see R02
        else $error("latch rising capture missed");
    fall_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        evt[EV_FALL_BIT] |=> latch_reg == $past(counterValue)) // see R03
        else $error("latch falling capture missed");
    no_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        !(|evt) |=> $stable(latch_reg)) // see R10
        else $error("latch changed without enabled edge");
    run_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        (fsm_reg == ST_RUNNING) [*2] |-> lampState) // see R04
        else $error("state lamp dark while running");
    start_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        (fsm_reg == ST_STARTUP) [*2] |-> !lampState) // see R04
        else $error("state lamp lit in startup");
    enc_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        lampEncoder == $past(encRdy_reg)) // see R05
        else $error("encoder lamp wrong");
    track_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(trackA) |-> ##3 lampTrackA) // see R06
        else $error("track lamp late");
    input_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        digitalIn [*4] |-> lampInput) // see R07
        else $error("input lamp dark");
    out_lamp_a: assert property (@(posedge clk) disable iff (!rstn)
        lampOutput == digitalOut) // see R08
        else $error("output lamp differs from output");
    safe_out_a: assert property (@(posedge clk) disable iff (!rstn)
        (fsm_reg != ST_RUNNING) |=> !digitalOut) // see R09
        else $error("output active outside running state");
    one_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        latchRise |=> !latchRise) // see R10
        else $error("double edge pulse");

    zero_cap_c:  cover property (@(posedge clk) evt[EV_ZERO_BIT]);
    rise_cap_c:  cover property (@(posedge clk) evt[EV_RISE_BIT]);
    fall_cap_c:  cover property (@(posedge clk) evt[EV_FALL_BIT]);
    irq_c:       cover property (@(posedge clk) $rose(irq));
endmodule

// ### tb/ell_enc_model.sv
`timescale 1ns/10ps
// Encoder and latch source; the count stands for the position counter
module ell_enc_model (
    input  wire logic   clk,
    input  wire logic   rstn,
    input  wire logic   stepEn,
    input  wire logic   zeroLvl,
    input  wire logic   latchLvl,
    output logic [31:0] count,
    output logic        trackA,
    output logic        trackB,
    output logic        trackZero,
    output logic        latchPin
);
    ////////////////////////////////////////////////////////////////////////
    // One step per enabled clock, so the bench can predict the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0000_0000;
        end else if (stepEn) begin
            count <= count + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tracks in quadrature; push-pull pins, so they never float
    assign trackA    = count[1];
    assign trackB    = count[1] ^ count[0];
    assign trackZero = zeroLvl;   // Zero mark only when commanded
    assign latchPin  = latchLvl;
endmodule

// ### tb/encoder_latch_status_leds_test.sv
`timescale 1ns/10ps
module encoder_latch_status_leds_test;
    import ell_pkg::*;
    logic        clk, rstn, avsRead, avsWrite, avsPage, digitalIn;
    logic        stepEn, zeroLvl, latchLvl, digitalOut, irq, avsWaitRequest;
    logic        lampState, lampEncoder, lampTrackA, lampTrackB;
    logic        lampTrackZero, lampInput, lampOutput;
    logic        trackA, trackB, trackZero, latchPin;
    logic [3:0]  avsAddress, avsByteEnable;
    logic [31:0] avsWriteData, avsReadData, count, expLatch, expCount;
    logic [8:0]  outs;
    int          num_errors, checks, hi[5], rs[5];
    ell_state_t  sts[5] = '{ST_STARTUP, ST_RUNNING, ST_GUARDED, ST_PREP,
                            ST_FWLOAD};

    assign outs = {lampState, lampEncoder, lampTrackA, lampTrackB,
                   lampTrackZero, lampInput, lampOutput, digitalOut, irq};

    ////////////////////////////////////////////////////////////////////////
    // Short lamp periods keep the run brief
    ell_latch_leds #(.BLINK_CYCLES(4), .FLICKER_CYCLES(2),
                     .SINGLE_OFF_CYCLES(8)) i_ell_latch_leds (
        .clk(clk), .rstn(rstn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsPage(avsPage),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .counterValue(count), .trackA(trackA), .trackB(trackB),
        .trackZero(trackZero), .latchPin(latchPin), .digitalIn(digitalIn),
        .digitalOut(digitalOut), .lampState(lampState),
        .lampEncoder(lampEncoder), .lampTrackA(lampTrackA),
        .lampTrackB(lampTrackB), .lampTrackZero(lampTrackZero),
        .lampInput(lampInput), .lampOutput(lampOutput), .irq(irq));
    ell_enc_model i_ell_enc_model (
        .clk(clk), .rstn(rstn), .stepEn(stepEn), .zeroLvl(zeroLvl),
        .latchLvl(latchLvl), .count(count), .trackA(trackA),
        .trackB(trackB), .trackZero(trackZero), .latchPin(latchPin));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access; request held until waitrequest is seen low
    task automatic busAcc(input logic wr, input logic pg,
                          input logic [3:0] ad, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        avsPage <= pg;
        avsAddress <= ad;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        if (avsWaitRequest !== 1'b0) begin
            num_errors++;
            end_sim();
        end
        // Read data stands at the edge that sees waitrequest low
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        // One idle edge so the next request never lands in this time step
        @(posedge clk);
    endtask

    task automatic wr(input logic pg, input logic [3:0] ad,
                      input logic [31:0] d);
        logic [31:0] q;
        busAcc(1'b1, pg, ad, d, q);
    endtask

    task automatic rdChk(input string what, input logic pg,
                         input logic [3:0] ad, input logic [31:0] exp);
        logic [31:0] q;
        busAcc(1'b0, pg, ad, 32'h0000_0000, q);
        check(what, q, exp);
    endtask

    // Bounded wait for masked outputs, then compare
    task automatic waitOut(input string what, input logic [8:0] m,
                           input logic [8:0] e);
        int n;
        for (n = 0; n < 12 && (outs & m) !== e; n++) @(posedge clk);
        check(what, {23'h0, outs & m}, {23'h0, e});
        if ((outs & m) !== e) begin
            end_sim();
        end
    endtask

    task automatic step(input int k);
        stepEn <= 1'b1;
        repeat (k) @(posedge clk);
        stepEn <= 1'b0;
        expCount = expCount + k;
    endtask

    // Count lit cycles and lamp rises over a fixed window
    task automatic lampRun(output int h, output int r);
        logic p;
        h = 0;
        r = 0;
        p = lampState;
        repeat (120) begin
            @(posedge clk);
            h += (lampState === 1'b1);
            r += (lampState === 1'b1 && p !== 1'b1);
            p = lampState;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, avsRead, avsWrite, avsPage, digitalIn} = '0;
        {stepEn, zeroLvl, latchLvl, avsAddress} = '0;
        {avsWriteData, expCount, expLatch} = '0;
        avsByteEnable = 4'hF;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        check("outs at reset", {23'h0, outs}, 32'h0000_0000);
        rdChk("ctrl reset", PAGE_LO, OFS_CTRL, {29'h0, CTRL_RESET});
        // Track and input lamps, with every capture disabled
        zeroLvl <= 1'b1;
        digitalIn <= 1'b1;
        step(2);
        waitOut("tracks on", 9'h078, 9'h078);
        zeroLvl <= 1'b0;
        digitalIn <= 1'b0;
        step(2);
        waitOut("tracks off", 9'h078, 9'h000);
        rdChk("latch idle", PAGE_LO, OFS_LATCH, 32'h0000_0000);
        wr(PAGE_HI, OFS_ENCRDY, 32'h0000_0001);
        waitOut("enc lamp on", 9'h080, 9'h080);
        wr(PAGE_HI, OFS_ENCRDY, 32'h0000_0000);
        waitOut("enc lamp off", 9'h080, 9'h000);
        // Output held safe except in the running state; lamp patterns
        wr(PAGE_HI, OFS_DOUT, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            wr(PAGE_HI, OFS_FSM, {29'h0, sts[i]});
            waitOut("dout", 9'h006, (i == 1) ? 9'h006 : 9'h000);
            lampRun(hi[i], rs[i]);
        end
        check("startup dark", hi[0], 0);
        check("running lit", {31'h0, hi[1] >= 112}, 1);
        check("prep blinks", {31'h0, rs[3] > 2 && hi[3] < 100}, 1);
        check("single flash", {31'h0, rs[2] > 0 && rs[2] < rs[3]}, 1);
        check("flicker", {31'h0, rs[4] > rs[3]}, 1);
        wr(PAGE_HI, OFS_FSM, {29'h0, ST_RUNNING});
        wr(PAGE_HI, OFS_DOUT, 32'h0000_0000);
        waitOut("dout clear", 9'h006, 9'h000);
        // Each enable against every edge kind; only its own edge captures
        wr(PAGE_HI, OFS_IRQEN, 32'h0000_0007);
        for (int i = 0; i < 3; i++) begin
            wr(PAGE_LO, OFS_CTRL, 32'h1 << i);
            for (int j = 0; j < 4; j++) begin
                step(1);
                if (j == 0) zeroLvl <= 1'b1;
                if (j == 1) latchLvl <= 1'b1;
                if (j == 2) latchLvl <= 1'b0;
                if (j == 3) zeroLvl <= 1'b0;
                if (j == i) expLatch = expCount;
                // Two sync stages, compare and latch: well under 8 clocks
                repeat (8) @(posedge clk);
            end
            rdChk("latch", PAGE_LO, OFS_LATCH, expLatch);
            rdChk("status", PAGE_LO, OFS_STATUS, 32'h1 << i);
            check("irq set", {31'h0, irq}, 1);
            wr(PAGE_LO, OFS_IRQCLR, 32'h1 << i);
            step(4);
            rdChk("no recapture", PAGE_LO, OFS_LATCH, expLatch);
            rdChk("status clr", PAGE_LO, OFS_STATUS, 0);
            check("irq clr", {31'h0, irq}, 0);
        end
        // Masked event stays pending, then raises irq once enabled
        wr(PAGE_HI, OFS_IRQEN, 32'h0000_0000);
        wr(PAGE_LO, OFS_CTRL, 32'h0000_0001);
        zeroLvl <= 1'b1;
        repeat (8) @(posedge clk);
        rdChk("masked stat", PAGE_LO, OFS_STATUS, 1);
        check("irq masked", {31'h0, irq}, 0);
        wr(PAGE_HI, OFS_IRQEN, 32'h0000_0001);
        waitOut("irq unmasked", 9'h001, 9'h001);
        // Refused accesses leave registers as they were
        avsByteEnable <= 4'h0;
        wr(PAGE_LO, OFS_CTRL, 32'h0000_0007);
        avsByteEnable <= 4'hF;
        rdChk("ctrl kept", PAGE_LO, OFS_CTRL, 1);
        wr(PAGE_LO, OFS_LATCH, 32'hFFFF_FFFF);
        rdChk("latch ro", PAGE_LO, OFS_LATCH, expCount);
        rdChk("unmapped", PAGE_LO, 4'h2, 0);
        end_sim();
    end
endmodule
